// *** eelc_defs.svh ***
// Constants of the edge event line controller: offsets, fields, resets.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef EELC_DEFS_SVH
`define EELC_DEFS_SVH

`define EELC_NUM_LINES    32
`define EELC_NUM_EXT      16
`define EELC_NUM_PINS     87
`define EELC_SEL_W        7
`define EELC_SEL_SLOT     8
`define EELC_SEL_PER_WORD 4

`define EELC_ADDR_W       8
`define EELC_OFF_IMR      8'h00
`define EELC_OFF_EMR      8'h04
`define EELC_OFF_RTSR     8'h08
`define EELC_OFF_FTSR     8'h0c
`define EELC_OFF_SWTRG    8'h10
`define EELC_OFF_PEND     8'h14
`define EELC_OFF_STAT     8'h18
`define EELC_OFF_IEN      8'h1c
`define EELC_OFF_SEL0     8'h20
`define EELC_OFF_SEL1     8'h24
`define EELC_OFF_SEL2     8'h28
`define EELC_OFF_SEL3     8'h2c

`define EELC_STAT_W       2
`define EELC_STAT_IRQ     0
`define EELC_STAT_EVT     1

`define EELC_RST_WORD     32'h0000_0000
`define EELC_RST_STAT     2'h0

`define EELC_RESP_OKAY    2'h0
`define EELC_RESP_SLVERR  2'h2

`endif

// *** eelc_pkg.sv ***
// Types of the edge event line controller.
// Assumes nothing beyond a SystemVerilog compiler.
package eelc_pkg;

    typedef enum logic [1:0] {
        EELC_RD_IDLE = 2'h1,
        EELC_RD_RESP = 2'h2
    } eelc_rd_e;

    typedef enum logic [1:0] {
        EELC_WR_COLLECT = 2'h1,
        EELC_WR_RESP    = 2'h2
    } eelc_wr_e;

endpackage

// *** eelc_line.sv ***
// One edge detector line: keeps last sample, flags the selected edges.
// Assumes the line input is synchronous to aclk.
`timescale 1ns/1ps
module eelc_line (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Line and trigger selection
    input  wire logic line_in,
    input  wire logic rise_en,
    input  wire logic fall_en,
    // Result
    output logic      edge_hit
);

    logic prev_q;
    logic prev_d;

    // No filter: a pulse held for a single cycle still gives two edges
    always_comb begin
        prev_d   = line_in;
        edge_hit = (rise_en & line_in & ~prev_q)
                 | (fall_en & ~line_in & prev_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

endmodule

// *** eelc_top.sv ***
// Edge event line controller with AXI4-Lite register slave.
// Assumes all pin and internal line inputs synchronous to aclk.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "eelc_defs.svh"
module eelc_top (
    // Clock and reset
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    // AXI4-Lite write address
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [`EELC_ADDR_W-1:0]          s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    // AXI4-Lite write response
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    output logic [1:0]                            s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    input  wire logic [`EELC_ADDR_W-1:0]          s_axi_araddr,
    // AXI4-Lite read data
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    // Line sources
    input  wire logic [`EELC_NUM_PINS-1:0]        gpio_in,
    input  wire logic [`EELC_NUM_LINES-`EELC_NUM_EXT-1:0] int_line_in,
    // Requests
    output logic [`EELC_NUM_LINES-1:0]            irq_line,
    output logic [`EELC_NUM_LINES-1:0]            evt_line,
    output logic                                  wakeup,
    output logic                                  irq
);

    localparam int NL = `EELC_NUM_LINES;

    // Configuration and state
    logic [NL-1:0] imr_q,  imr_d;
    logic [NL-1:0] emr_q,  emr_d;
    logic [NL-1:0] rtsr_q, rtsr_d;
    logic [NL-1:0] ftsr_q, ftsr_d;
    logic [NL-1:0] pend_q, pend_d;
    logic [31:0]   sel_q [4];
    logic [31:0]   sel_d [4];
    logic [`EELC_STAT_W-1:0] stat_q, stat_d;
    logic [`EELC_STAT_W-1:0] ien_q,  ien_d;
    logic [NL-1:0] irq_line_d, evt_line_d;
    logic          wakeup_d, irq_d;

    // Bus channel state
    eelc_pkg::eelc_wr_e wst_q, wst_d;
    eelc_pkg::eelc_rd_e rst_q, rst_d;
    logic                    aw_have_q, aw_have_d;
    logic                    w_have_q,  w_have_d;
    logic [`EELC_ADDR_W-1:0] waddr_q,   waddr_d;
    logic [31:0]             wdata_q,   wdata_d;
    logic [3:0]              wstrb_q,   wstrb_d;
    logic [1:0]              bresp_q,   bresp_d;
    logic [31:0]             rdata_q,   rdata_d;
    logic [1:0]              rresp_q,   rresp_d;

    // Line inputs and edge results
    logic [NL-1:0] line_in;
    logic [NL-1:0] edge_hit;
    logic [NL-1:0] sw_trig;

    genvar gi;
    generate
        for (gi = 0; gi < `EELC_NUM_EXT; gi++) begin : g_mux
            logic [`EELC_SEL_W-1:0] sel;
            assign sel = sel_q[gi / `EELC_SEL_PER_WORD]
                         [(gi % `EELC_SEL_PER_WORD) * `EELC_SEL_SLOT +: `EELC_SEL_W];
            // Out-of-range selector reads as a quiet line
            assign line_in[gi] = (sel < `EELC_SEL_W'(`EELC_NUM_PINS)) ?
                                 gpio_in[sel] : 1'b0;
        end
        for (gi = 0; gi < NL; gi++) begin : g_line
            eelc_line u_line (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .line_in  (line_in[gi]),
                .rise_en  (rtsr_q[gi]),
                .fall_en  (ftsr_q[gi]),
                .edge_hit (edge_hit[gi])
            );
        end
    endgenerate

    assign line_in[NL-1:`EELC_NUM_EXT] = int_line_in;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Write channel: address and data taken in either order
    logic do_write;
    logic aw_take, w_take, ar_take;
    assign aw_take  = s_axi_awvalid & s_axi_awready;
    assign w_take   = s_axi_wvalid & s_axi_wready;
    assign ar_take  = s_axi_arvalid & s_axi_arready;
    assign do_write = (wst_q == eelc_pkg::EELC_WR_COLLECT) & aw_have_q & w_have_q;

    always_comb begin
        wst_d     = wst_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bresp_d   = bresp_q;
        case (wst_q)
            eelc_pkg::EELC_WR_COLLECT: begin
                if (aw_take) begin
                    aw_have_d = 1'b1;
                    waddr_d   = s_axi_awaddr;
                end
                if (w_take) begin
                    w_have_d = 1'b1;
                    wdata_d  = s_axi_wdata;
                    wstrb_d  = s_axi_wstrb;
                end
                if (do_write) begin
                    aw_have_d = 1'b0;
                    w_have_d  = 1'b0;
                    wst_d     = eelc_pkg::EELC_WR_RESP;
                    bresp_d   = (waddr_q[1:0] == 2'h0 && waddr_q <= `EELC_OFF_SEL3) ?
                                `EELC_RESP_OKAY : `EELC_RESP_SLVERR;
                end
            end
            eelc_pkg::EELC_WR_RESP: begin
                if (s_axi_bready) begin
                    wst_d = eelc_pkg::EELC_WR_COLLECT;
                end
            end
            default: begin
                wst_d = eelc_pkg::EELC_WR_COLLECT;
            end
        endcase
    end

    // Read channel
    logic stat_read;
    assign stat_read = ar_take && (s_axi_araddr == `EELC_OFF_STAT);

    always_comb begin
        rst_d   = rst_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        case (rst_q)
            eelc_pkg::EELC_RD_IDLE: begin
                // Only a real handshake may start a read; arready is low just after reset
                if (ar_take) begin
                    rst_d   = eelc_pkg::EELC_RD_RESP;
                    rresp_d = `EELC_RESP_OKAY;
                    case (s_axi_araddr)
                        `EELC_OFF_IMR:   rdata_d = imr_q;
                        `EELC_OFF_EMR:   rdata_d = emr_q;
                        `EELC_OFF_RTSR:  rdata_d = rtsr_q;
                        `EELC_OFF_FTSR:  rdata_d = ftsr_q;
                        `EELC_OFF_SWTRG: rdata_d = `EELC_RST_WORD;
                        `EELC_OFF_PEND:  rdata_d = pend_q;
                        `EELC_OFF_STAT:  rdata_d = {30'h0, stat_q};
                        `EELC_OFF_IEN:   rdata_d = {30'h0, ien_q};
                        `EELC_OFF_SEL0:  rdata_d = sel_q[0];
                        `EELC_OFF_SEL1:  rdata_d = sel_q[1];
                        `EELC_OFF_SEL2:  rdata_d = sel_q[2];
                        `EELC_OFF_SEL3:  rdata_d = sel_q[3];
                        default: begin
                            rdata_d = `EELC_RST_WORD;
                            rresp_d = `EELC_RESP_SLVERR;
                        end
                    endcase
                end
            end
            eelc_pkg::EELC_RD_RESP: begin
                if (s_axi_rready) begin
                    rst_d = eelc_pkg::EELC_RD_IDLE;
                end
            end
            default: begin
                rst_d = eelc_pkg::EELC_RD_IDLE;
            end
        endcase
    end

    // Register file, pending and request logic
    logic [NL-1:0] hit;
    logic [NL-1:0] pend_clr;
    always_comb begin
        imr_d    = imr_q;
        emr_d    = emr_q;
        rtsr_d   = rtsr_q;
        ftsr_d   = ftsr_q;
        ien_d    = ien_q;
        sel_d    = sel_q;
        sw_trig  = '0;
        pend_clr = '0;
        if (do_write) begin
            case (waddr_q)
                `EELC_OFF_IMR:   imr_d  = merge(imr_q, wdata_q, wstrb_q);
                `EELC_OFF_EMR:   emr_d  = merge(emr_q, wdata_q, wstrb_q);
                `EELC_OFF_RTSR:  rtsr_d = merge(rtsr_q, wdata_q, wstrb_q);
                `EELC_OFF_FTSR:  ftsr_d = merge(ftsr_q, wdata_q, wstrb_q);
                `EELC_OFF_SWTRG: sw_trig = merge('0, wdata_q, wstrb_q);
                `EELC_OFF_PEND:  pend_clr = merge('0, wdata_q, wstrb_q);
                `EELC_OFF_IEN: begin
                    if (wstrb_q[0]) begin
                        ien_d = wdata_q[`EELC_STAT_W-1:0];
                    end
                end
                `EELC_OFF_SEL0:  sel_d[0] = merge(sel_q[0], wdata_q, wstrb_q);
                `EELC_OFF_SEL1:  sel_d[1] = merge(sel_q[1], wdata_q, wstrb_q);
                `EELC_OFF_SEL2:  sel_d[2] = merge(sel_q[2], wdata_q, wstrb_q);
                `EELC_OFF_SEL3:  sel_d[3] = merge(sel_q[3], wdata_q, wstrb_q);
                default: ;
            endcase
        end
        hit = edge_hit | sw_trig;
        // New edge beats a same-cycle clear so no event is lost
        pend_d     = (pend_q & ~pend_clr) | hit;
        irq_line_d = pend_d & imr_q;
        evt_line_d = hit & emr_q;
        wakeup_d   = |irq_line_d | |evt_line_d;
        stat_d     = stat_read ? `EELC_RST_STAT : stat_q;
        if (|(hit & imr_q)) begin
            stat_d[`EELC_STAT_IRQ] = 1'b1;
        end
        if (|evt_line_d) begin
            stat_d[`EELC_STAT_EVT] = 1'b1;
        end
        irq_d = |(stat_d & ien_d);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q     <= eelc_pkg::EELC_WR_COLLECT;
            rst_q     <= eelc_pkg::EELC_RD_IDLE;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= `EELC_RST_WORD;
            wstrb_q   <= 4'h0;
            bresp_q   <= `EELC_RESP_OKAY;
            rdata_q   <= `EELC_RST_WORD;
            rresp_q   <= `EELC_RESP_OKAY;
            imr_q     <= `EELC_RST_WORD;
            emr_q     <= `EELC_RST_WORD;
            rtsr_q    <= `EELC_RST_WORD;
            ftsr_q    <= `EELC_RST_WORD;
            pend_q    <= `EELC_RST_WORD;
            for (int i = 0; i < 4; i++) begin
                sel_q[i] <= `EELC_RST_WORD;
            end
            stat_q    <= `EELC_RST_STAT;
            ien_q     <= `EELC_RST_STAT;
            irq_line  <= '0;
            evt_line  <= '0;
            wakeup    <= 1'b0;
            irq       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_rvalid  <= 1'b0;
        end else begin
            wst_q     <= wst_d;
            rst_q     <= rst_d;
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bresp_q   <= bresp_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            imr_q     <= imr_d;
            emr_q     <= emr_d;
            rtsr_q    <= rtsr_d;
            ftsr_q    <= ftsr_d;
            pend_q    <= pend_d;
            sel_q     <= sel_d;
            stat_q    <= stat_d;
            ien_q     <= ien_d;
            irq_line  <= irq_line_d;
            evt_line  <= evt_line_d;
            wakeup    <= wakeup_d;
            irq       <= irq_d;
            s_axi_awready <= (wst_d == eelc_pkg::EELC_WR_COLLECT) & ~aw_have_d;
            s_axi_wready  <= (wst_d == eelc_pkg::EELC_WR_COLLECT) & ~w_have_d;
            s_axi_arready <= (rst_d == eelc_pkg::EELC_RD_IDLE);
            s_axi_bvalid  <= (wst_d == eelc_pkg::EELC_WR_RESP);
            s_axi_rvalid  <= (rst_d == eelc_pkg::EELC_RD_RESP);
        end
    end

    assign s_axi_bresp  = bresp_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule

// *** eelc_chk.sv ***
// Port checker of the edge event line controller.
// Assumes binding onto eelc_top; sees only its ports.
`timescale 1ns/1ps
module eelc_chk (
    // Clock, reset and bus
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Lines and requests
    input wire logic [15:0] int_line_in,
    input wire logic [31:0] irq_line,
    input wire logic [31:0] evt_line,
    input wire logic        wakeup
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_wake_follows: assert property (
        wakeup == |(irq_line | evt_line)) else $error("wakeup differs from requests");
    // The bench keeps the software trigger off lines 16..31, so only a change may pulse them
    a_evt_needs_edge: assert property (
        (evt_line[31:16] & ~($past(int_line_in) ^ $past(int_line_in, 2))) == 16'h0)
        else $error("event pulse without input change");
    a_irq_drop_wr: assert property (
        |($past(irq_line) & ~irq_line) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt request dropped without a write");
    a_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_b_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_r_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_wr_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
endmodule

bind eelc_top eelc_chk u_chk (.*);

// *** eelc_pins.sv ***
// Model of the pins and internal sources that feed the lines.
// Assumes the bench sets levels and one-cycle inversions after edges.
`timescale 1ns/1ps
module eelc_pins (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Requested levels and one-cycle inversions
    input  wire logic [86:0] pin_lvl,
    input  wire logic [15:0] int_lvl,
    input  wire logic [86:0] pin_pls,
    input  wire logic [15:0] int_pls,
    // Driven sources
    output logic      [86:0] gpio_in,
    output logic      [15:0] int_line_in
);
    // Pins sit low in reset so no stale edge is seen on release
    always_ff @(posedge aclk) begin
        gpio_in     <= aresetn ? pin_lvl ^ pin_pls : '0;
        int_line_in <= aresetn ? int_lvl ^ int_pls : '0;
    end
endmodule

// *** eelc_tb_top.sv ***
// Bench of the edge event line controller: bus master, model, checks.
// Assumes eelc_top, eelc_pins and the bound checker are compiled.
`timescale 1ns/1ps
module eelc_tb_top;
    logic        aclk = '0, aresetn = '0, s_axi_bready = '0, s_axi_rready = '0;
    logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, irq_line, evt_line, evt_seen, v;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, m_stat, m_ien;
    logic [86:0] gpio_in, pin_lvl = '0, pin_pls = '0;
    logic [15:0] int_line_in, int_lvl = '0, int_pls = '0;
    logic        wakeup, irq;
    logic [31:0] m_imr, m_emr, m_rise, m_fall, m_pend;
    int          m_sel[16];
    int          miscompares = 0, checks = 0;

    eelc_top dut (.*);
    eelc_pins u_pins (.*);

    always #25 aclk = ~aclk;

    task automatic summarize();
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 200) begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        repeat ($urandom % 3) tick(n);
        s_axi_bready <= 1'h1;
        do tick(n); while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'h0;
        cmp(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do tick(n); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        repeat ($urandom % 3) tick(n);
        s_axi_rready <= 1'h1;
        do tick(n); while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'h0;
        cmp(s_axi_rdata, ed);
        cmp(32'(s_axi_rresp), 32'(er));
    endtask

    // Selectors at or above the pin count leave the line low
    function automatic logic [31:0] lines(input logic [86:0] p, input logic [15:0] q);
        logic [31:0] l;
        l = {q, 16'h0};
        for (int i = 0; i < 16; i++) l[i] = (m_sel[i] < 87) ? p[m_sel[i]] : 1'h0;
        return l;
    endfunction

    task automatic note(input logic [31:0] e);
        m_pend |= e;
        m_stat |= {|(e & m_emr), |(e & m_imr)};
    endtask

    task automatic chk_out();
        repeat (2) @(posedge aclk);
        cmp(irq_line, m_pend & m_imr);
        cmp(32'(wakeup), 32'(|(m_pend & m_imr)));
        cmp(32'(irq), 32'(|(m_stat & m_ien)));
    endtask

    // A pulse gives both edges, so either trigger enable catches it
    task automatic step(input logic [86:0] p, input logic [15:0] q, input logic pls);
        logic [31:0] o, nw, e;
        o = lines(pin_lvl, int_lvl);
        nw = lines(pls ? pin_lvl ^ p : p, pls ? int_lvl ^ q : q);
        e = pls ? (o ^ nw) & (m_rise | m_fall) : nw & ~o & m_rise | o & ~nw & m_fall;
        if (pls) begin
            pin_pls <= p;
            int_pls <= q;
        end else begin
            pin_lvl <= p;
            int_lvl <= q;
        end
        @(posedge aclk);
        pin_pls <= '0;
        int_pls <= '0;
        evt_seen = '0;
        repeat (4) begin
            @(posedge aclk);
            evt_seen |= evt_line;
        end
        note(e);
        cmp(evt_seen, e & m_emr);
        chk_out();
        rd(8'h14, m_pend, 2'h0);
    endtask

    initial begin
        void'($urandom(45));
        {m_imr, m_emr, m_rise, m_fall, m_pend, m_stat, m_ien} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (int i = 0; i < 12; i++) rd(8'(4 * i), '0, 2'h0);
        rd(8'h30, '0, 2'h2);
        rd(8'h06, '0, 2'h2);
        wr(8'h31, 32'hffff_ffff, 2'h2);
        for (int i = 0; i < 14; i++) m_sel[i] = $urandom % 87;
        m_sel[14] = 86;
        m_sel[15] = 87;
        for (int w = 0; w < 4; w++) begin
            for (int b = 0; b < 4; b++) v[8*b +: 8] = 8'(m_sel[4*w+b]);
            wr(8'(32 + 4*w), v, 2'h0);
            rd(8'(32 + 4*w), v, 2'h0);
        end
        m_imr = $urandom;
        m_emr = $urandom;
        m_rise = $urandom;
        m_fall = $urandom;
        wr(8'h00, m_imr, 2'h0);
        wr(8'h04, m_emr, 2'h0);
        wr(8'h08, m_rise, 2'h0);
        wr(8'h0c, m_fall, 2'h0);
        rd(8'h0c, m_fall, 2'h0);
        // Byte lanes 0 and 2 only: the other lanes must keep their value
        s_axi_wstrb <= 4'h5;
        wr(8'h04, ~m_emr, 2'h0);
        m_emr = m_emr ^ 32'h00ff_00ff;
        s_axi_wstrb <= 4'hf;
        rd(8'h04, m_emr, 2'h0);
        for (int r = 0; r < 24; r++) begin
            step(87'({$urandom, $urandom, $urandom}), 16'($urandom), r % 3 == 2);
            if (r % 6 == 5) begin
                v = $urandom;
                wr(8'h14, v, 2'h0);
                m_pend &= ~v;
                chk_out();
                rd(8'h18, 32'(m_stat), 2'h0);
                m_stat = '0;
                m_ien = 2'(r / 6);
                wr(8'h1c, 32'(m_ien), 2'h0);
                chk_out();
            end
        end
        wr(8'h14, '0, 2'h0);
        v = {16'h0, 16'($urandom)};
        wr(8'h10, v, 2'h0);
        note(v);
        rd(8'h10, '0, 2'h0);
        rd(8'h14, m_pend, 2'h0);
        chk_out();
        m_imr = '0;
        wr(8'h00, m_imr, 2'h0);
        chk_out();
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(8'h14, '0, 2'h0);
        summarize();
    end
endmodule
